// ==== hdl/dual_timer_counter.sv ====
// two timer/counter modules with mode, control and count registers
// What this block does
// [RULE1] mode field: 00 13-bit, 01 16-bit, 10 auto reload, 11 splits module zero
// [RULE2] module one in mode 11 halts and keeps its count, like clearing run
// [RULE3] qualify bit set: interrupt pin must be high to clock, besides run
// [RULE4] timer select 0: count system clock over 12, or over 4 with divide select
// [RULE5] counter mode: count pin fall, run fall, qualify rise or gate pin fall
// [RULE6] any other control and pin combination leaves the count unchanged
// [RULE7] external count pin runs at most one eighth of the system clock
// [RULE8] 13-bit mode uses high byte and low five bits of low byte
// [RULE9] 13 and 16-bit modes set overflow flag when high byte wraps to zero
// [RULE10] overflow flag clears on software write 0 or on its vector
// [RULE11] software write 1 sets the overflow flag and requests an interrupt
// [RULE12] run bit 0 blocks clocking of that module, but not of module one or the module zero high byte while split
// [RULE13] reload mode: low byte counts, reloads from high byte on overflow
// [RULE14] split: low byte gated as usual, high byte gated by module one run
// [RULE15] split: module zero high byte drives module one overflow flag
// [RULE16] split: module one still counts and supplies baud overflow
// [RULE17] only module one overflow is offered as serial reference clock
// [RULE18] edge type: flag set on pin fall, cleared by vector or write 0
// [RULE19] level type: flag follows pin, set while low, clear while high
// [RULE20] prescaler ticks every 12 or 4 clocks; pins synced and edge detected
// [RULE21] 16-bit mode: low byte carries into high byte on rollover
module dual_timer_counter
  import timer_pkg::*;
(
  input wire logic clk_sys, // system clock, 40 MHz
  input wire logic rst, // async reset, active high
  input wire sfr_req_t sfr_req, // register bus request from the core
  output logic [7:0] sfr_rdata, // registered read data
  input wire logic count_pin_zero, // external count pin, module zero
  input wire logic count_pin_one, // external count pin, module one
  input wire logic ext_irq_pin_zero, // external interrupt pin zero
  input wire logic ext_irq_pin_one, // external interrupt pin one
  input wire logic [1:0] divide_select, // per module: 1 selects divide by 4
  input wire logic [1:0] timer_vector_ack, // pulse: core vectors to timer routine
  input wire logic [1:0] ext_vector_ack, // pulse: core vectors to ext routine
  output logic [1:0] timer_irq, // overflow flags, one and zero
  output logic [1:0] ext_irq, // external interrupt flags
  output logic baud_tick // module one overflow pulse for serial ports
);
  logic tick_slow;
  logic tick_fast;
  logic [3:0] pin_level;
  logic [3:0] pin_fall;
  logic [7:0] mode_reg;
  logic [1:0] run_reg;
  logic [1:0] flag_reg;
  logic [1:0] ext_flag_reg;
  logic [1:0] ext_type_reg;
  logic split;
  logic one_halted;
  wire [1:0] inc;
  wire [1:0] ovf;
  wire [1:0] src_evt;
  wire [1:0][7:0] low_q;
  wire [1:0][7:0] high_q;
  wire high_split_ovf;
  logic [1:0] flag_set;
  logic wr_ctl;

  tick_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick_slow(tick_slow),
    .tick_fast(tick_fast)
  );

  // bits 1:0 count pins, bits 3:2 interrupt pins
  pin_sync #(.W(4)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({ext_irq_pin_one, ext_irq_pin_zero, count_pin_one, count_pin_zero}),
    .level(pin_level),
    .fall(pin_fall)
  );

  assign split = (mode_reg[MODE_SEL_POS +: 2] == MODE_SPLIT); // RULE1
  assign one_halted = (mode_reg[MODE_STRIDE + MODE_SEL_POS +: 2] == MODE_SPLIT); // RULE2
  assign wr_ctl = sfr_req.wr && (sfr_req.addr == ADDR_CONTROL);

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : timer_g
      localparam logic [7:0] ADDR_LO = (i == 0) ? ADDR_LOW_ZERO : ADDR_LOW_ONE;
      localparam logic [7:0] ADDR_HI = (i == 0) ? ADDR_HIGH_ZERO : ADDR_HIGH_ONE;
      logic [1:0] mode;
      logic ct_sel;
      logic qual;
      logic gate_ok;
      logic run_eff;
      logic tick;
      logic pin_gate;
      logic pin_gate_reg;
      logic [7:0] low_reg;
      logic [7:0] high_reg;
      logic [7:0] low_next;
      logic [7:0] high_next;
      logic ovf_l;
      logic hi_ovf_l;

      assign mode = mode_reg[MODE_STRIDE * i + MODE_SEL_POS +: 2];
      assign ct_sel = mode_reg[MODE_STRIDE * i + MODE_CT_POS];
      assign qual = mode_reg[MODE_STRIDE * i + MODE_QUAL_POS];
      assign gate_ok = ~qual | pin_level[2 + i]; // RULE3
      assign tick = divide_select[i] ? tick_fast : tick_slow; // RULE4
      assign src_evt[i] = ct_sel ? pin_fall[i] : tick;

      // module one runs free while module zero is split, unless itself halted
      if (i == 0)
      begin : run0_g
        assign run_eff = run_reg[0]; // RULE12
      end
      else
      begin : run1_g
        assign run_eff = one_halted ? 1'b0 : (split | run_reg[1]); // RULE2 RULE16 RULE12
      end

      // every counter-mode transition is a fall of pin AND run AND gate
      assign pin_gate = pin_level[i] & run_eff & gate_ok;

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          pin_gate_reg <= 1'b0;
        else
          pin_gate_reg <= pin_gate;
      end

      assign inc[i] = ct_sel ? (pin_gate_reg & ~pin_gate) // RULE5
                             : (tick & run_eff & gate_ok); // RULE4 RULE12

      always_comb
      begin
        low_next = low_reg; // RULE6
        high_next = high_reg;
        ovf_l = 1'b0;
        hi_ovf_l = 1'b0;
        if (inc[i])
        begin
          unique case (mode)
            MODE_13BIT:
            begin
              low_next[4:0] = low_reg[4:0] + 5'h01; // RULE8
              if (low_reg[4:0] == LOW5_MAX)
              begin
                high_next = high_reg + 8'h01;
                ovf_l = (high_reg == BYTE_MAX); // RULE9
              end
            end
            MODE_16BIT:
            begin
              {high_next, low_next} = {high_reg, low_reg} + 16'h0001; // RULE21
              ovf_l = (low_reg == BYTE_MAX) && (high_reg == BYTE_MAX); // RULE9
            end
            MODE_RELOAD:
            begin
              low_next = (low_reg == BYTE_MAX) ? high_reg : low_reg + 8'h01; // RULE13
              ovf_l = (low_reg == BYTE_MAX);
            end
            MODE_SPLIT:
            begin
              if (i == 0)
              begin
                low_next = low_reg + 8'h01; // RULE14
                ovf_l = (low_reg == BYTE_MAX);
              end
            end
          endcase
        end
        // split high byte: same source, gated by module one run only
        if (i == 0 && split && src_evt[0] && run_reg[1])
        begin
          high_next = high_reg + 8'h01; // RULE14
          hi_ovf_l = (high_reg == BYTE_MAX);
        end
      end

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          low_reg <= RESET_COUNT;
        else if (sfr_req.wr && sfr_req.addr == ADDR_LO)
          low_reg <= sfr_req.wdata;
        else
          low_reg <= low_next;
      end

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          high_reg <= RESET_COUNT;
        else if (sfr_req.wr && sfr_req.addr == ADDR_HI)
          high_reg <= sfr_req.wdata;
        else
          high_reg <= high_next;
      end

      assign ovf[i] = ovf_l;
      assign low_q[i] = low_reg;
      assign high_q[i] = high_reg;
      if (i == 0)
      begin : split_ovf_g
        assign high_split_ovf = hi_ovf_l;
      end
    end
  endgenerate

  // module one flag comes from module zero high byte while split
  assign flag_set[0] = ovf[0];
  assign flag_set[1] = split ? high_split_ovf : ovf[1]; // RULE15

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mode_reg <= RESET_MODE;
    else if (sfr_req.wr && sfr_req.addr == ADDR_MODE)
      mode_reg <= sfr_req.wdata; // RULE1
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      run_reg <= RESET_CONTROL[CTL_RUN_POS +: 2];
      ext_type_reg <= RESET_CONTROL[CTL_EXT_TYPE_POS +: 2];
    end
    else if (wr_ctl)
    begin
      for (int k = 0; k < 2; k++)
      begin
        run_reg[k] <= sfr_req.wdata[CTL_RUN_POS + CTL_STRIDE * k];
        ext_type_reg[k] <= sfr_req.wdata[CTL_EXT_TYPE_POS + CTL_STRIDE * k];
      end
    end
  end

  // overflow flags: hardware set wins over any clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      flag_reg <= RESET_CONTROL[CTL_FLAG_POS +: 2];
    else
    begin
      for (int k = 0; k < 2; k++)
      begin
        if (flag_set[k])
          flag_reg[k] <= 1'b1; // RULE9 RULE15
        else if (wr_ctl)
          flag_reg[k] <= sfr_req.wdata[CTL_FLAG_POS + CTL_STRIDE * k]; // RULE10 RULE11
        else if (timer_vector_ack[k])
          flag_reg[k] <= 1'b0; // RULE10
      end
    end
  end

  // external interrupt flags, edge or level per type bit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ext_flag_reg <= RESET_CONTROL[CTL_EXT_FLAG_POS +: 2];
    else
    begin
      for (int k = 0; k < 2; k++)
      begin
        if (!ext_type_reg[k])
          ext_flag_reg[k] <= ~pin_level[2 + k]; // RULE19
        else if (pin_fall[2 + k])
          ext_flag_reg[k] <= 1'b1; // RULE18
        else if (wr_ctl)
          ext_flag_reg[k] <= sfr_req.wdata[CTL_EXT_FLAG_POS + CTL_STRIDE * k]; // RULE18
        else if (ext_vector_ack[k])
          ext_flag_reg[k] <= 1'b0; // RULE18
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      timer_irq <= 2'h0;
      ext_irq <= 2'h0;
      baud_tick <= 1'b0;
    end
    else
    begin
      timer_irq <= flag_reg; // RULE11
      ext_irq <= ext_flag_reg;
      baud_tick <= ovf[1]; // RULE17 RULE16
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sfr_rdata <= READ_UNMAPPED;
    else if (sfr_req.rd)
    begin
      unique case (sfr_req.addr)
        ADDR_CONTROL: sfr_rdata <= {flag_reg[1], run_reg[1], flag_reg[0], run_reg[0],
                                    ext_flag_reg[1], ext_type_reg[1],
                                    ext_flag_reg[0], ext_type_reg[0]};
        ADDR_MODE: sfr_rdata <= mode_reg;
        ADDR_LOW_ZERO: sfr_rdata <= low_q[0];
        ADDR_LOW_ONE: sfr_rdata <= low_q[1];
        ADDR_HIGH_ZERO: sfr_rdata <= high_q[0];
        ADDR_HIGH_ONE: sfr_rdata <= high_q[1];
        default: sfr_rdata <= READ_UNMAPPED;
      endcase
    end
  end
endmodule

// ==== hdl/pin_sync.sv ====
// two-flop synchronisers with falling-edge detect for external pins
module pin_sync #(
  parameter int W = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [W-1:0] pin_in, // raw pins
  output logic [W-1:0] level, // synchronised level
  output logic [W-1:0] fall // one-cycle pulse on high-to-low
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] last_reg;

  // idle-high pins reset high so release gives no false edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '1;
      level <= '1;
      last_reg <= '1;
    end
    else
    begin
      meta_reg <= pin_in;
      level <= meta_reg;
      last_reg <= level;
    end
  end

  assign fall = last_reg & ~level; // RULE20
endmodule

// ==== hdl/tick_prescaler.sv ====
// system clock prescaler giving one-cycle ticks every 12 and every 4 clocks
module tick_prescaler
  import timer_pkg::*;
#(
  parameter int SLOW = DIV_SLOW,
  parameter int FAST = DIV_FAST
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  output logic tick_slow, // pulse every SLOW clocks
  output logic tick_fast // pulse every FAST clocks
);
  localparam int SW = $clog2(SLOW);
  localparam int FW = $clog2(FAST);
  localparam logic [SW-1:0] SLOW_LAST = SW'(SLOW - 1);
  localparam logic [FW-1:0] FAST_LAST = FW'(FAST - 1);
  logic [SW-1:0] slow_cnt_reg;
  logic [FW-1:0] fast_cnt_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      slow_cnt_reg <= '0;
      tick_slow <= 1'b0;
    end
    else
    begin
      slow_cnt_reg <= (slow_cnt_reg == SLOW_LAST) ? '0 : slow_cnt_reg + 1'b1;
      tick_slow <= (slow_cnt_reg == SLOW_LAST); // RULE20
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fast_cnt_reg <= '0;
      tick_fast <= 1'b0;
    end
    else
    begin
      fast_cnt_reg <= (fast_cnt_reg == FAST_LAST) ? '0 : fast_cnt_reg + 1'b1;
      tick_fast <= (fast_cnt_reg == FAST_LAST); // RULE20
    end
  end
endmodule

// ==== hdl/timer_pkg.sv ====
// constants and types shared by the timer/counter block
package timer_pkg;
  // register offsets on the special function register bus
  localparam logic [7:0] ADDR_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_LOW_ZERO = 8'h8a;
  localparam logic [7:0] ADDR_LOW_ONE = 8'h8b;
  localparam logic [7:0] ADDR_HIGH_ZERO = 8'h8c;
  localparam logic [7:0] ADDR_HIGH_ONE = 8'h8d;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_MODE = 8'h00;
  localparam logic [7:0] RESET_COUNT = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // timer_control fields, per module i: flag at 5+2i, run at 4+2i
  localparam int CTL_RUN_POS = 4;
  localparam int CTL_FLAG_POS = 5;
  localparam int CTL_EXT_TYPE_POS = 0;
  localparam int CTL_EXT_FLAG_POS = 1;
  localparam int CTL_STRIDE = 2;
  // timer_mode fields, per module i at offset 4i
  localparam int MODE_SEL_POS = 0;
  localparam int MODE_CT_POS = 2;
  localparam int MODE_QUAL_POS = 3;
  localparam int MODE_STRIDE = 4;
  // mode_sel_high:mode_sel_low codes
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [4:0] LOW5_MAX = 5'h1f;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  // prescaler divisors
  localparam int DIV_SLOW = 12;
  localparam int DIV_FAST = 4;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;
endpackage

// ==== tb/cpu_model.sv ====
// core-side model driving the special function register bus
module cpu_model
  import timer_pkg::*;
(
  input wire logic clk_sys, // system clock
  output sfr_req_t sfr_req // request to the block
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sfr_req = '0;
  // one access: raised after an edge, held over the taking edge, then released
  task automatic put(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    sfr_req <= '{a, w, !w, d};
    @(posedge clk_sys);
    #2;
    sfr_req <= '0;
  endtask
endmodule

// ==== tb/dual_timer_counter_checker.sv ====
// port assertions for the dual timer/counter block
module dual_timer_counter_checker
  import timer_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset
  input wire sfr_req_t sfr_req, // bus request
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic ext_irq_pin_zero, // gate pin zero
  input wire logic [1:0] ext_vector_ack, // ext vector pulses
  input wire logic [1:0] timer_irq, // overflow flags
  input wire logic [1:0] ext_irq, // ext flags
  input wire logic baud_tick // serial reference
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mode_sh;
  logic type_sh;
  logic wr_ctl;
  assign wr_ctl = sfr_req.wr && sfr_req.addr == ADDR_CONTROL;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mode_sh <= RESET_MODE;
    else if (sfr_req.wr && sfr_req.addr == ADDR_MODE)
      mode_sh <= sfr_req.wdata;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      type_sh <= 1'b0;
    else if (wr_ctl)
      type_sh <= sfr_req.wdata[CTL_EXT_TYPE_POS];
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence level_low_s;
    (!type_sh && !ext_irq_pin_zero)[*6];
  endsequence
  sequence level_high_s;
    (!type_sh && ext_irq_pin_zero)[*6];
  endsequence
  sequence edge_idle_s;
    (type_sh && ext_irq_pin_zero)[*4];
  endsequence
  mode_readback_a: assert property (sfr_req.rd && sfr_req.addr == ADDR_MODE
    |=> sfr_rdata == $past(mode_sh)) else $error("mode register read back wrong");
  flag_set_zero_a: assert property (wr_ctl && sfr_req.wdata[CTL_FLAG_POS]
    |-> ##2 timer_irq[0]) else $error("overflow flag zero not set by write");
  flag_set_one_a: assert property (wr_ctl && sfr_req.wdata[CTL_FLAG_POS + CTL_STRIDE]
    |-> ##2 timer_irq[1]) else $error("overflow flag one not set by write");
  level_low_a: assert property (level_low_s |-> ext_irq[0])
    else $error("level flag not set while pin low");
  level_high_a: assert property (level_high_s |-> !ext_irq[0])
    else $error("level flag not clear while pin high");
  edge_set_a: assert property (type_sh && $fell(ext_irq_pin_zero)
    |-> ##[2:6] ext_irq[0]) else $error("edge flag not set on falling pin");
  edge_clear_a: assert property (edge_idle_s ##0 (ext_vector_ack[0] && !wr_ctl)
    |-> ##2 !ext_irq[0]) else $error("edge flag not cleared by vector");
  baud_pulse_a: assert property (baud_tick |=> !baud_tick)
    else $error("baud tick longer than one cycle");
endmodule
bind dual_timer_counter dual_timer_counter_checker i_dual_timer_counter_checker (
  .clk_sys(clk_sys), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .ext_irq_pin_zero(ext_irq_pin_zero), .ext_vector_ack(ext_vector_ack),
  .timer_irq(timer_irq), .ext_irq(ext_irq), .baud_tick(baud_tick)
);

// ==== tb/testbench.sv ====
// self-checking bench for the dual timer/counter block
module testbench
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  sfr_req_t sfr_req;
  logic [7:0] sfr_rdata;
  logic [1:0] cnt_pin = 2'b11;
  logic [1:0] irq_pin = 2'b11;
  logic [1:0] div_sel = 2'b00;
  logic [1:0] t_ack = 2'b00;
  logic [1:0] e_ack = 2'b00;
  logic [1:0] timer_irq;
  logic [1:0] ext_irq;
  logic baud_tick;
  int num_errors = 0;
  int n_tests = 0;
  typedef struct {string nm; logic [7:0] v;} note_t;
  note_t notes[$];
  note_t nt;
  initial forever #12.5 clk_sys = ~clk_sys;
  cpu_model i_cpu_model (.clk_sys(clk_sys), .sfr_req(sfr_req));
  dual_timer_counter i_dual_timer_counter (
    .clk_sys(clk_sys), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .count_pin_zero(cnt_pin[0]), .count_pin_one(cnt_pin[1]),
    .ext_irq_pin_zero(irq_pin[0]), .ext_irq_pin_one(irq_pin[1]),
    .divide_select(div_sel), .timer_vector_ack(t_ack), .ext_vector_ack(e_ack),
    .timer_irq(timer_irq), .ext_irq(ext_irq), .baud_tick(baud_tick)
  );
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_cpu_model.put(a, 1'b1, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    notes.push_back('{nm, e});
    i_cpu_model.put(a, 1'b0, 8'h00);
  endtask
  // read results appear just after the taking edge and are checked 5 ns later
  always @(posedge clk_sys)
  begin
    if (sfr_req.rd === 1'b1)
    begin
      #5;
      nt = notes.pop_front();
      check(nt.nm, sfr_rdata, nt.v);
    end
  end
  task automatic pulse_pin(input int b);
    cnt_pin[b] = 1'b0;
    step(4);
    cnt_pin[b] = 1'b1;
    step(4);
  endtask
  task automatic period(input logic [7:0] e);
    realtime t_start;
    repeat (2) @(posedge baud_tick);
    t_start = $realtime;
    @(posedge baud_tick);
    check("baud period", 8'(int'(($realtime - t_start) / 25.0)), e);
    step(1);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #(10000 * 25);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    int n;
    logic [7:0] v;
    n = $urandom(79075);
    step(5);
    rst = 1'b0;
    step(1);
    rd("control", ADDR_CONTROL, RESET_CONTROL);
    rd("mode", ADDR_MODE, RESET_MODE);
    wr(8'h8e, 8'hff);
    rd("unmapped", 8'h8e, READ_UNMAPPED);
    repeat (4)
    begin
      v = 8'($urandom);
      wr(ADDR_MODE, v);
      rd("mode", ADDR_MODE, v);
    end
    done("registers");
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CONTROL, 8'h20);
    rd("flag set", ADDR_CONTROL, 8'h20);
    t_ack[0] = 1'b1;
    step(1);
    t_ack[0] = 1'b0;
    rd("flag vector", ADDR_CONTROL, 8'h00);
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_CONTROL, 8'h00);
    rd("flag write", ADDR_CONTROL, 8'h00);
    done("flags");
    wr(ADDR_MODE, 8'h20);
    wr(ADDR_HIGH_ONE, 8'hff);
    wr(ADDR_LOW_ONE, 8'hff);
    wr(ADDR_CONTROL, 8'h40);
    period(8'd12);
    div_sel = 2'b10;
    period(8'd4);
    wr(ADDR_HIGH_ONE, 8'hfe);
    period(8'd8);
    check("reload flag", {6'h00, timer_irq}, 8'h02);
    wr(ADDR_CONTROL, 8'h00);
    done("reload");
    wr(ADDR_MODE, 8'h23);
    wr(ADDR_HIGH_ZERO, 8'hff);
    wr(ADDR_LOW_ZERO, 8'h10);
    div_sel = 2'b11;
    wr(ADDR_CONTROL, 8'h40);
    repeat (20) if (timer_irq[1] !== 1'b1) step(1);
    check("split high", {6'h00, timer_irq}, 8'h02);
    rd("split low", ADDR_LOW_ZERO, 8'h10);
    wr(ADDR_CONTROL, 8'h00);
    period(8'd8);
    check("split one", {6'h00, timer_irq}, 8'h00);
    done("split");
    wr(ADDR_MODE, 8'h31);
    wr(ADDR_LOW_ONE, 8'h55);
    wr(ADDR_LOW_ZERO, 8'h66);
    wr(ADDR_CONTROL, 8'h40);
    step(40);
    rd("halted one", ADDR_LOW_ONE, 8'h55);
    rd("stopped zero", ADDR_LOW_ZERO, 8'h66);
    done("halt");
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, 8'h09);
    wr(ADDR_HIGH_ZERO, 8'hff);
    wr(ADDR_LOW_ZERO, 8'hff);
    irq_pin[0] = 1'b0;
    wr(ADDR_CONTROL, 8'h10);
    step(40);
    rd("gated", ADDR_CONTROL, 8'h12);
    irq_pin[0] = 1'b1;
    repeat (20) if (timer_irq[0] !== 1'b1) step(1);
    check("gate open", {6'h00, timer_irq}, 8'h01);
    rd("overflow", ADDR_CONTROL, 8'h30);
    done("gate");
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_LOW_ZERO, 8'h00);
    wr(ADDR_HIGH_ZERO, 8'h00);
    wr(ADDR_CONTROL, 8'h10);
    n = $urandom_range(9, 3);
    repeat (n) pulse_pin(0);
    wr(ADDR_CONTROL, 8'h00);
    step(6);
    rd("events", ADDR_LOW_ZERO, 8'(n + 1));
    wr(ADDR_MODE, 8'h04);
    wr(ADDR_LOW_ZERO, 8'hff);
    wr(ADDR_CONTROL, 8'h10);
    pulse_pin(0);
    wr(ADDR_CONTROL, 8'h00);
    step(6);
    rd("short low", ADDR_LOW_ZERO, 8'he1);
    rd("short high", ADDR_HIGH_ZERO, 8'h01);
    done("counter");
    wr(ADDR_CONTROL, 8'h01);
    irq_pin = 2'b00;
    step(6);
    check("edge flag", {6'h00, ext_irq}, 8'h03);
    irq_pin = 2'b11;
    step(5);
    e_ack[0] = 1'b1;
    step(1);
    e_ack[0] = 1'b0;
    step(2);
    check("edge cleared", {6'h00, ext_irq}, 8'h00);
    done("edge");
    wr(ADDR_CONTROL, 8'ha0);
    step(2);
    check("flags before reset", {6'h00, timer_irq}, 8'h03);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
    check("flags after reset", {6'h00, timer_irq}, 8'h00);
    rd("control reset", ADDR_CONTROL, RESET_CONTROL);
    rd("count reset", ADDR_LOW_ZERO, RESET_COUNT);
    step(1);
    done("reset");
    wrap_up();
  end
endmodule
